// ### rtl/i2cac_pkg.sv
/*
 * Constants for the I2C address, command port and high-count block:
 * register byte addresses, reset values, field positions and event bits.
 * Assumes a 32-bit APB with byte addresses and one register per word.
 */
`default_nettype none

package i2cac_pkg;

    // =========================================================
    // Register byte addresses
    localparam logic [31:0] ADDR_OWN = 32'h5000_1308;
    localparam logic [31:0] ADDR_DATA = 32'h5000_1310;
    localparam logic [31:0] ADDR_HCNT = 32'h5000_1314;
    localparam logic [31:0] ADDR_CTRL = 32'h5000_1380;
    localparam logic [31:0] ADDR_FLAGS = 32'h5000_1384;
    localparam logic [31:0] ADDR_MASK = 32'h5000_1388;

    // =========================================================
    // Reset values and limits
    localparam logic [9:0] OWN_RST = 10'h055;
    localparam logic [15:0] HCNT_RST = 16'h0048;
    localparam logic [15:0] HCNT_MIN = 16'h0006;
    localparam logic [15:0] IDLE_MARGIN = 16'h000a;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [11:0] MASK_RST = 12'h000;

    // =========================================================
    // Field positions
    localparam int CMD_READ_BIT = 8;
    localparam int CTRL_ON = 0;
    localparam int CTRL_MASTER = 1;
    localparam int CTRL_SLV10 = 2;
    localparam int CTRL_SPECIAL = 3;
    localparam int CTRL_GC_START = 4;

    // Event bits of raw_interrupt_flags
    localparam int NEV = 12;
    localparam int EV_RX_AVAIL = 2;
    localparam int EV_RD_REQ = 5;
    localparam int EV_ABORT = 6;
    localparam int EV_IDLE = 8;

    // 10-bit address preamble
    localparam logic [4:0] TEN_BIT_TAG = 5'h1e;

    // =========================================================
    // Slave address recogniser states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ADDR1 = 4'b0010,
        ST_ADDR2 = 4'b0100,
        ST_DATA = 4'b1000
    } i2cac_state_e;

endpackage

`default_nettype wire

// ### rtl/i2cac_top.sv
/*
 * Register-facing part of an I2C controller: own slave address and its
 * recogniser, data command port with transmit and receive FIFOs, standard
 * speed SCL high-period timer, bus idle detection, abort events, interrupt.
 * Assumes an APB master, a byte engine beside it on the same clock, and
 * SCL and SDA pins from outside the clock domain.
 */
`default_nettype none

module i2cac_top
    import i2cac_pkg::*;
#(
    parameter int TX_DEPTH = 8,
    parameter int RX_DEPTH = 8
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // I2C pins, observed only
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    // Transmit entries towards the byte engine
    output logic TX_VALID,
    output logic [7:0] TX_BYTE,
    output logic TX_READ,
    input wire logic TX_TAKE,
    // Received bytes from the byte engine
    input wire logic RX_PUSH,
    input wire logic [7:0] RX_BYTE_IN,
    output logic RX_FULL,
    // SCL high phase timer
    input wire logic SCL_HIGH_GO,
    output logic SCL_HIGH_END,
    // Status
    output logic BUS_IDLE,
    output logic SLAVE_SELECTED,
    output logic SLAVE_READ_REQ,
    output logic IRQ
);

    localparam int TXW = $clog2(TX_DEPTH);
    localparam int RXW = $clog2(RX_DEPTH);

    // =========================================================
    // Registers
    logic [9:0] own_address_field;
    logic [15:0] std_speed_high_count;
    logic [4:0] ctrl;
    logic [NEV-1:0] raw_interrupt_flags;
    logic [NEV-1:0] mask;

    wire controller_on = ctrl[CTRL_ON];
    wire master_mode = ctrl[CTRL_MASTER];
    wire slave_ten_bit = ctrl[CTRL_SLV10];
    // General Call mode lasts as long as special stays set and GC start stays clear
    wire general_call = ctrl[CTRL_SPECIAL] & ~ctrl[CTRL_GC_START];

    // =========================================================
    // APB decode; one wait state so that read data leaves a flop
    wire access = PSEL & PENABLE;
    wire done = access & PREADY;
    wire wr_done = done & PWRITE;
    wire rd_done = done & ~PWRITE;
    wire hit_own = PADDR == ADDR_OWN;
    wire hit_data = PADDR == ADDR_DATA;
    wire hit_hcnt = PADDR == ADDR_HCNT;
    wire hit_ctrl = PADDR == ADDR_CTRL;
    wire hit_flags = PADDR == ADDR_FLAGS;
    wire hit_mask = PADDR == ADDR_MASK;
    wire mapped = hit_own | hit_data | hit_hcnt | hit_ctrl | hit_flags | hit_mask;

    // =========================================================
    // Pin synchronisers; stage one feeds only stage two
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;

    always_ff @(posedge CLK_SYS) begin
        scl_s1 <= SCL_IN;
        scl_s2 <= scl_s1;
        scl_s3 <= scl_s2;
        sda_s1 <= SDA_IN;
        sda_s2 <= sda_s1;
        sda_s3 <= sda_s2;
    end

    wire scl_rise = scl_s2 & ~scl_s3;
    wire bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    wire bus_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

    // =========================================================
    // Address shifter: eight data bits then the acknowledge clock
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    wire [7:0] next_byte = {shreg[6:0], sda_s2};
    wire byte_done = scl_rise & (bitcnt == 4'h7);

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || bus_start || bus_stop) begin
            shreg <= 8'h00;
            bitcnt <= 4'h0;
        end else if (scl_rise) begin
            shreg <= next_byte;
            bitcnt <= (bitcnt == 4'h8) ? 4'h0 : bitcnt + 4'h1;
        end
    end

    // =========================================================
    // Slave address recogniser
    i2cac_state_e state, next_state;
    logic ten_bit_hit, next_ten_bit_hit;
    logic rd_req_set;

    wire match7 = next_byte[7:1] == own_address_field[6:0];
    wire match10_hi = (next_byte[7:3] == TEN_BIT_TAG) && (next_byte[2:1] == own_address_field[9:8]);
    wire match10_lo = next_byte == own_address_field[7:0];

    always_comb begin
        next_state = state;
        next_ten_bit_hit = ten_bit_hit;
        rd_req_set = 1'b0;
        if (!controller_on || bus_stop) begin
            next_state = ST_IDLE;
            next_ten_bit_hit = 1'b0;
        end else if (bus_start) begin
            next_state = ST_ADDR1;
        end else if (byte_done) begin
            case (state)
                ST_ADDR1: begin
                    if (slave_ten_bit) begin
                        if (match10_hi && !next_byte[0]) begin
                            next_state = ST_ADDR2;
                        end else if (match10_hi && ten_bit_hit) begin
                            next_state = ST_DATA;
                            rd_req_set = 1'b1;
                        end else begin
                            next_state = ST_IDLE;
                            next_ten_bit_hit = 1'b0;
                        end
                    end else if (match7) begin
                        next_state = ST_DATA;
                        rd_req_set = next_byte[0];
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
                ST_ADDR2: begin
                    next_state = match10_lo ? ST_DATA : ST_IDLE;
                    next_ten_bit_hit = match10_lo;
                end
                ST_DATA: next_state = ST_DATA;
                ST_IDLE: next_state = ST_IDLE;
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            state <= ST_IDLE;
            ten_bit_hit <= 1'b0;
        end else begin
            state <= next_state;
            ten_bit_hit <= next_ten_bit_hit;
        end
    end

    // =========================================================
    // Data command port write checks
    wire port_write = wr_done & hit_data;
    wire cmd_read = PWDATA[CMD_READ_BIT];
    logic rd_req_pending;
    // A read request in the same cycle counts as pending already
    wire rd_req_now = rd_req_pending | rd_req_set;
    wire abort_gc = port_write & cmd_read & general_call;
    wire abort_rdreq = port_write & cmd_read & rd_req_now;
    wire discard = abort_gc | abort_rdreq;
    // Read commands carry no data byte
    wire [8:0] entry = cmd_read ? {1'b1, 8'h00} : {1'b0, PWDATA[7:0]};

    // Pending until serviced by a written data byte or ended by stop or by switching the controller off
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            rd_req_pending <= 1'b0;
        end else if (rd_req_set) begin
            rd_req_pending <= 1'b1;
        end else if ((port_write && !cmd_read) || bus_stop || !controller_on) begin
            rd_req_pending <= 1'b0;
        end
    end

    // =========================================================
    // Transmit FIFO with a registered output stage
    logic [8:0] tx_mem [TX_DEPTH];
    logic [TXW-1:0] tx_wp, tx_rp;
    logic [TXW:0] tx_cnt;
    wire tx_push = port_write & ~discard & (tx_cnt != TX_DEPTH[TXW:0]);
    wire tx_load = (~TX_VALID | TX_TAKE) & (tx_cnt != '0);
    wire [TXW:0] tx_inc = {{TXW{1'b0}}, tx_push};
    wire [TXW:0] tx_dec = {{TXW{1'b0}}, tx_load};

    always_ff @(posedge CLK_SYS) begin
        if (tx_push) begin
            tx_mem[tx_wp] <= entry;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            tx_wp <= '0;
            tx_rp <= '0;
            tx_cnt <= '0;
        end else begin
            tx_wp <= tx_wp + TXW'(tx_push);
            tx_rp <= tx_rp + TXW'(tx_load);
            tx_cnt <= tx_cnt + tx_inc - tx_dec;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            TX_VALID <= 1'b0;
            TX_BYTE <= 8'h00;
            TX_READ <= 1'b0;
        end else if (tx_load) begin
            TX_VALID <= 1'b1;
            TX_BYTE <= tx_mem[tx_rp][7:0];
            // As slave the remote master decides direction
            TX_READ <= tx_mem[tx_rp][CMD_READ_BIT] & master_mode;
        end else if (TX_TAKE) begin
            TX_VALID <= 1'b0;
        end
    end

    // =========================================================
    // Receive FIFO; a full FIFO drops further bytes
    logic [7:0] rx_mem [RX_DEPTH];
    logic [RXW-1:0] rx_wp, rx_rp;
    logic [RXW:0] rx_cnt;
    wire rx_in = RX_PUSH & (rx_cnt != RX_DEPTH[RXW:0]);
    wire rx_pop = rd_done & hit_data & (rx_cnt != '0);
    wire [RXW:0] rx_inc = {{RXW{1'b0}}, rx_in};
    wire [RXW:0] rx_dec = {{RXW{1'b0}}, rx_pop};
    wire [RXW:0] next_rx_cnt = rx_cnt + rx_inc - rx_dec;

    always_ff @(posedge CLK_SYS) begin
        if (rx_in) begin
            rx_mem[rx_wp] <= RX_BYTE_IN;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            rx_wp <= '0;
            rx_rp <= '0;
            rx_cnt <= '0;
            RX_FULL <= 1'b0;
        end else begin
            rx_wp <= rx_wp + RXW'(rx_in);
            rx_rp <= rx_rp + RXW'(rx_pop);
            rx_cnt <= next_rx_cnt;
            RX_FULL <= next_rx_cnt == RX_DEPTH[RXW:0];
        end
    end

    // =========================================================
    // Configuration registers; own address and high count frozen while the controller runs
    wire [15:0] hcnt_clamped = (PWDATA[15:0] < HCNT_MIN) ? HCNT_MIN : PWDATA[15:0];

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            own_address_field <= OWN_RST;
            std_speed_high_count <= HCNT_RST;
            ctrl <= CTRL_RST;
            mask <= MASK_RST;
        end else if (wr_done) begin
            if (hit_own && !controller_on) begin
                own_address_field <= PWDATA[9:0];
            end
            if (hit_hcnt && !controller_on) begin
                std_speed_high_count <= hcnt_clamped;
            end
            if (hit_ctrl) begin
                ctrl <= PWDATA[4:0];
            end
            if (hit_mask) begin
                mask <= PWDATA[NEV-1:0];
            end
        end
    end

    // =========================================================
    // Bus idle: both lines high for high count plus ten cycles
    // Counts above 65525 would wrap this 16-bit counter
    logic [15:0] idle_cnt;
    wire [15:0] idle_limit = std_speed_high_count + IDLE_MARGIN;

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || !(scl_s2 && sda_s2)) begin
            idle_cnt <= 16'h0000;
            BUS_IDLE <= 1'b0;
        end else begin
            if (idle_cnt != idle_limit) begin
                idle_cnt <= idle_cnt + 16'h0001;
            end
            BUS_IDLE <= idle_cnt == idle_limit;
        end
    end

    logic idle_q;
    always_ff @(posedge CLK_SYS) begin
        idle_q <= SYS_RST ? 1'b0 : BUS_IDLE;
    end

    // =========================================================
    // SCL high phase timer at standard speed
    logic [15:0] high_cnt;
    logic high_run;

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            high_cnt <= 16'h0000;
            high_run <= 1'b0;
            SCL_HIGH_END <= 1'b0;
        end else if (SCL_HIGH_GO) begin
            high_cnt <= std_speed_high_count - 16'h0001;
            high_run <= 1'b1;
            SCL_HIGH_END <= 1'b0;
        end else begin
            SCL_HIGH_END <= high_run && (high_cnt == 16'h0000);
            if (high_cnt == 16'h0000) begin
                high_run <= 1'b0;
            end else begin
                high_cnt <= high_cnt - 16'h0001;
            end
        end
    end

    // =========================================================
    // Events, read-to-clear flags and interrupt
    logic [NEV-1:0] events;
    always_comb begin
        events = '0;
        events[EV_RX_AVAIL] = rx_in;
        events[EV_RD_REQ] = rd_req_set;
        events[EV_ABORT] = discard;
        events[EV_IDLE] = BUS_IDLE & ~idle_q;
    end

    // New events win over the clear of the same read
    wire flags_clear = rd_done & hit_flags;
    wire [NEV-1:0] next_flags = (flags_clear ? '0 : raw_interrupt_flags) | events;

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            raw_interrupt_flags <= '0;
            IRQ <= 1'b0;
        end else begin
            raw_interrupt_flags <= next_flags;
            IRQ <= |(next_flags & mask);
        end
    end

    // =========================================================
    // Status outputs
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            SLAVE_SELECTED <= 1'b0;
            SLAVE_READ_REQ <= 1'b0;
        end else begin
            SLAVE_SELECTED <= next_state == ST_DATA;
            SLAVE_READ_REQ <= rd_req_set | (rd_req_pending & ~(port_write & ~cmd_read) & ~bus_stop);
        end
    end

    // =========================================================
    // Read mux and APB answer
    wire [31:0] rd_value =
        hit_own ? {22'h0, own_address_field} :
        hit_data ? {24'h0, (rx_cnt != '0) ? rx_mem[rx_rp] : 8'h00} :
        hit_hcnt ? {16'h0, std_speed_high_count} :
        hit_ctrl ? {27'h0, ctrl} :
        hit_flags ? {20'h0, raw_interrupt_flags} :
        hit_mask ? {20'h0, mask} : 32'h0;

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= access & ~PREADY;
            PSLVERR <= access & ~PREADY & ~mapped;
            if (access && !PREADY && !PWRITE) begin
                PRDATA <= rd_value;
            end
        end
    end

endmodule // i2cac_top

`default_nettype wire

// ### sim/i2cac_remote.sv
/*
 * Remote bus master model driving SCL and SDA as seen after the pull-ups.
 * Assumes the bench calls one task at a time; both lines idle high.
 */
`default_nettype none

module i2cac_remote (
    // Bus lines
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // Framing: 48 ns per SCL period, SCL still between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic start();
        #12 sda = 1'b0;
        #24 scl = 1'b0;
    endtask

    // Ninth bit is released, so the pull-up shows high
    task automatic send(input logic [7:0] b);
        logic [8:0] f;
        f = {b, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            #12 sda = f[i];
            #12 scl = 1'b1;
            #24 scl = 1'b0;
        end
    endtask

    task automatic stop();
        #12 sda = 1'b0;
        #12 scl = 1'b1;
        #24 sda = 1'b1;
    endtask
endmodule // i2cac_remote

`default_nettype wire

// ### sim/i2cac_assertions.sv
/*
 * Checker for i2cac_top: APB timing, register locks, entries and timers.
 * Assumes it is bound to i2cac_top and sees only its ports.
 */
`default_nettype none

module i2cac_chk
    import i2cac_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    // Bus lines
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    // Engine side
    input wire logic TX_VALID,
    input wire logic [7:0] TX_BYTE,
    input wire logic TX_READ,
    input wire logic TX_TAKE,
    input wire logic SCL_HIGH_GO,
    input wire logic SCL_HIGH_END,
    input wire logic BUS_IDLE
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // Shadow copies, since the registers are out of sight
    logic [9:0] own_sh;
    logic [15:0] hc;
    logic on_sh;
    logic [31:0] hi_cnt;
    wire wr_ok = PSEL && PENABLE && PREADY && PWRITE;
    wire cfg_ok = wr_ok && !on_sh;
    wire [15:0] hc_w = (PWDATA[15:0] < HCNT_MIN) ? HCNT_MIN : PWDATA[15:0];
    wire [9:0] next_own = (cfg_ok && PADDR == ADDR_OWN) ? PWDATA[9:0] : own_sh;
    wire [15:0] next_hc = (cfg_ok && PADDR == ADDR_HCNT) ? hc_w : hc;
    wire next_on = (wr_ok && PADDR == ADDR_CTRL) ? PWDATA[CTRL_ON] : on_sh;
    wire [31:0] next_hi = (SCL_IN && SDA_IN) ? hi_cnt + 32'h1 : 32'h0;

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            own_sh <= OWN_RST;
            hc <= HCNT_RST;
            on_sh <= 1'b0;
            hi_cnt <= 32'h0;
        end else begin
            own_sh <= next_own;
            hc <= next_hc;
            on_sh <= next_on;
            hi_cnt <= next_hi;
        end
    end

    // ==========================================
    // Properties
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    sequence s_enter;
        PSEL && PENABLE && !$past(PENABLE);
    endsequence

    sequence s_high_wait;
        !SCL_HIGH_END [*6] ##1 SCL_HIGH_END;
    endsequence

    chk_one_wait: assert property (s_enter |-> !PREADY ##1 PREADY)
        else $error("APB answer not after one wait cycle");
    chk_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("APB ready longer than one cycle");
    chk_own_read: assert property (
        PREADY && !PWRITE && PADDR == ADDR_OWN |-> PRDATA == {22'h0, own_sh})
        else $error("Own address read wrong");
    chk_hcnt_read: assert property (
        PREADY && !PWRITE && PADDR == ADDR_HCNT |-> PRDATA == {16'h0, hc})
        else $error("High count read wrong");
    chk_read_byte: assert property (TX_VALID && TX_READ |-> TX_BYTE == 8'h00)
        else $error("Read entry carries data");
    chk_tx_hold: assert property (TX_VALID && !TX_TAKE |=> TX_VALID && $stable(TX_BYTE))
        else $error("Entry changed before taken");
    chk_high_end: assert property (SCL_HIGH_GO && hc == 16'h0006 |=> s_high_wait)
        else $error("High phase end mistimed");
    chk_idle_rise: assert property ($rose(BUS_IDLE) |-> hi_cnt >= hc + 11)
        else $error("Idle flagged too early");
    chk_idle_late: assert property (hi_cnt == hc + 16 |-> BUS_IDLE)
        else $error("Idle flagged too late");
    chk_idle_drop: assert property (BUS_IDLE && !(SCL_IN && SDA_IN) |-> ##[1:4] !BUS_IDLE)
        else $error("Idle kept with busy lines");
endmodule // i2cac_chk

bind i2cac_top i2cac_chk u_chk (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .TX_VALID(TX_VALID),
    .TX_BYTE(TX_BYTE), .TX_READ(TX_READ), .TX_TAKE(TX_TAKE),
    .SCL_HIGH_GO(SCL_HIGH_GO), .SCL_HIGH_END(SCL_HIGH_END), .BUS_IDLE(BUS_IDLE)
);

`default_nettype wire

// ### sim/tb.sv
/*
 * Self-checking bench for i2cac_top: APB master, byte engine stubs and
 * one task per scenario. Assumes i2cac_remote drives the bus lines.
 */
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %s expected %h seen %h", n, e, g); end end

module tb
    import i2cac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic CLK_SYS = 1'b0;
    logic SYS_RST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [31:0] PADDR = 32'h0;
    logic [31:0] PWDATA = 32'h0;
    logic TX_TAKE = 1'b0;
    logic RX_PUSH = 1'b0;
    logic [7:0] RX_BYTE_IN = 8'h00;
    logic SCL_HIGH_GO = 1'b0;
    logic SCL_IN, SDA_IN, PREADY, PSLVERR, TX_VALID, TX_READ, RX_FULL;
    logic SCL_HIGH_END, BUS_IDLE, SLAVE_SELECTED, SLAVE_READ_REQ, IRQ;
    logic [31:0] PRDATA;
    logic [7:0] TX_BYTE;
    logic [31:0] rdat;
    logic last_err;
    int miscompares = 0;
    int samples_checked = 0;

    i2cac_remote u_rem (.scl(SCL_IN), .sda(SDA_IN));
    i2cac_top u_dut (.*);

    initial begin
        forever #2.5 CLK_SYS = ~CLK_SYS;
    end

    // ==========================================
    // Shared tasks
    task automatic tally_and_finish();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Idle cycle after each transfer keeps strobes from being set twice at one edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (PREADY !== 1'b1 && n < 40);
        if (n == 40) miscompares++;
        rdat = PRDATA;
        last_err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK_SYS);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("register read", e, rdat & m)
    endtask

    task automatic settle();
        repeat (4) @(posedge CLK_SYS);
    endtask

    task automatic take(input logic r_e, input logic [7:0] b_e);
        int n;
        n = 0;
        while (TX_VALID !== 1'b1 && n < 20) begin
            @(posedge CLK_SYS);
            n++;
        end
        `CHK("entry valid", 1'b1, TX_VALID)
        `CHK("entry read", r_e, TX_READ)
        `CHK("entry byte", b_e, TX_BYTE)
        TX_TAKE <= 1'b1;
        @(posedge CLK_SYS);
        TX_TAKE <= 1'b0;
        @(posedge CLK_SYS);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        rd(ADDR_OWN, '1, 32'h55);
        rd(ADDR_HCNT, '1, 32'h48);
        rd(ADDR_DATA, '1, 32'h0);
        rd(32'h5000_13fc, '1, 32'h0);
        `CHK("slave error", 1'b1, last_err)
    endtask

    task automatic t_lock();
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_OWN, 32'h3ff);
        wr(ADDR_HCNT, 32'h20);
        rd(ADDR_OWN, '1, 32'h55);
        rd(ADDR_HCNT, '1, 32'h48);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_OWN, 32'h2a5);
        rd(ADDR_OWN, '1, 32'h2a5);
        wr(ADDR_HCNT, 32'h5);
        rd(ADDR_HCNT, '1, 32'h6);
        wr(ADDR_HCNT, 32'h7);
        rd(ADDR_HCNT, '1, 32'h7);
        wr(ADDR_HCNT, 32'h6);
    endtask

    task automatic t_timer();
        int n;
        n = 0;
        SCL_HIGH_GO <= 1'b1;
        @(posedge CLK_SYS);
        SCL_HIGH_GO <= 1'b0;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (SCL_HIGH_END !== 1'b1 && n < 40);
        // END is launched hcnt edges after GO and seen one edge later
        `CHK("high phase cycles", int'(HCNT_MIN) + 1, n)
    endtask

    task automatic t_tx();
        wr(ADDR_CTRL, 32'h3);
        wr(ADDR_DATA, 32'h1a5);
        wr(ADDR_DATA, 32'h0c3);
        take(1'b1, 8'h00);
        take(1'b0, 8'hc3);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_DATA, 32'h1a5);
        take(1'b0, 8'h00);
    endtask

    task automatic t_rx();
        RX_BYTE_IN <= 8'h3c;
        RX_PUSH <= 1'b1;
        @(posedge CLK_SYS);
        RX_BYTE_IN <= 8'ha7;
        repeat (7) @(posedge CLK_SYS);
        RX_PUSH <= 1'b0;
        @(posedge CLK_SYS);
        `CHK("rx full", 1'b1, RX_FULL)
        rd(ADDR_FLAGS, 32'h4, 32'h4);
        rd(ADDR_DATA, '1, 32'h3c);
        rd(ADDR_DATA, '1, 32'ha7);
        `CHK("rx not full", 1'b0, RX_FULL)
        repeat (6) rd(ADDR_DATA, '1, 32'ha7);
        rd(ADDR_DATA, '1, 32'h0);
    endtask

    task automatic t_gc();
        wr(ADDR_CTRL, 32'hb);
        wr(ADDR_MASK, 32'h40);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        wr(ADDR_DATA, 32'h100);
        settle();
        `CHK("raised irq", 1'b1, IRQ)
        `CHK("entry valid", 1'b0, TX_VALID)
        rd(ADDR_FLAGS, 32'h40, 32'h40);
        settle();
        `CHK("cleared irq", 1'b0, IRQ)
        wr(ADDR_MASK, 32'h0);
        wr(ADDR_DATA, 32'h100);
        settle();
        `CHK("masked irq", 1'b0, IRQ)
        rd(ADDR_FLAGS, 32'h40, 32'h40);
        wr(ADDR_CTRL, 32'h3);
        wr(ADDR_DATA, 32'h100);
        take(1'b1, 8'h00);
    endtask

    task automatic t_slave();
        wr(ADDR_CTRL, 32'h1);
        u_rem.start();
        u_rem.send({7'h55, 1'b0});
        settle();
        `CHK("foreign address", 1'b0, SLAVE_SELECTED)
        u_rem.stop();
        u_rem.start();
        u_rem.send({7'h25, 1'b1});
        settle();
        `CHK("own address", 1'b1, SLAVE_SELECTED)
        `CHK("read request", 1'b1, SLAVE_READ_REQ)
        wr(ADDR_DATA, 32'h100);
        rd(ADDR_FLAGS, 32'h60, 32'h60);
        wr(ADDR_DATA, 32'h055);
        take(1'b0, 8'h55);
        `CHK("request served", 1'b0, SLAVE_READ_REQ)
        u_rem.stop();
        settle();
        wr(ADDR_CTRL, 32'h5);
        u_rem.start();
        u_rem.send({5'h1e, 2'b10, 1'b0});
        u_rem.send(8'ha5);
        settle();
        `CHK("long address", 1'b1, SLAVE_SELECTED)
        u_rem.stop();
        repeat (15) @(posedge CLK_SYS);
        `CHK("idle early", 1'b0, BUS_IDLE)
        repeat (8) @(posedge CLK_SYS);
        `CHK("idle flagged", 1'b1, BUS_IDLE)
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (20) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        @(posedge CLK_SYS);
        t_reset();
        t_lock();
        t_timer();
        t_tx();
        t_rx();
        t_gc();
        t_slave();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge CLK_SYS);
        miscompares++;
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire
